//--- reset_out_receiver.sv
// Purpose: external device that receives the watchdog reset output
// Assumes: samples the pin on the system clock
// Notes:   counts finished low pulses and the width of the last one
`timescale 1ns/1ps
module reset_out_receiver (
  input  wire logic  clk,             // system clock
  input  wire logic  reset_out_pin_n, // reset request, active low
  output logic [15:0] pulses,         // finished pulses
  output logic [15:0] last_width      // cycles of last pulse
);
  logic [15:0] width = 16'h0000;
  initial pulses = 16'h0000;
  initial last_width = 16'h0000;
  // a pulse is only counted once it ends, so a stuck pin shows no pulse
  always @(posedge clk) begin
    if (!reset_out_pin_n) begin
      width <= width + 16'h0001;
    end else if (width != 16'h0000) begin
      last_width <= width;
      pulses <= pulses + 16'h0001;
      width <= 16'h0000;
    end
  end
endmodule // reset_out_receiver

//--- watchdog_interval_timer.sv
// Purpose: 8-bit watchdog / interval timer with password writes
// Assumes: synchronous register port, one access per clock, clk 250 MHz
// Notes:   reset is the external reset_in_pin; internal watchdog reset is
//          an output that the chip feeds back to the rest of the logic
`timescale 1ns/1ps
module watchdog_interval_timer (
  input  wire logic                 clk,           // system clock
  input  wire logic                 reset,         // pin reset, async high
  input  wire wdt_pkg::bus_req_type bus_req,       // register access
  output logic [7:0]                rdata,         // registered read data
  output logic                      interval_interrupt, // interval irq
  output logic                      chip_reset,    // internal chip reset
  output logic                      reset_out_pin_n // reset out, active low
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]    watch_counter;
    logic          overflow_flag;
    logic          timer_mode_select;
    logic          count_run_enable;
    logic [2:0]    clock_select;
    logic          watchdog_reset_flag;
    logic          reset_output_enable;
    logic          ovf_seen_set;     // overflow flag read as one
    logic          watchdog_reset_flag_seen_set;    // reset flag read as one
    logic [11:0]   prescaler;
    logic [9:0]    rst_count;
    rst_state_type rst_state;
    logic [7:0]    rdata;
    logic          irq;
    logic          chip_reset;
    logic          reset_out_n;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // prescaler tap for each clock select code
  function automatic logic tick_of(input logic [2:0] sel,
                                   input logic [11:0] pre_now,
                                   input logic [11:0] pre_nxt);
    logic [3:0] tap;
    tap = 4'h0;
    unique case (sel)
      3'h0: tap = 4'h0;   // /2
      3'h1: tap = 4'h4;   // /32
      3'h2: tap = 4'h5;   // /64
      3'h3: tap = 4'h6;   // /128
      3'h4: tap = 4'h7;   // /256
      3'h5: tap = 4'h8;   // /512
      3'h6: tap = 4'hA;   // /2048
      3'h7: tap = 4'hB;   // /4096
    endcase
    // falling edge of the tap bit gives one pulse per period
    return pre_now[tap] & ~pre_nxt[tap];
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        wr_word;
    logic        wr_timer;
    logic        wr_reset;
    logic [7:0]  key;
    logic [7:0]  data;
    logic        tick;
    logic        overflow;
    logic [11:0] pre_inc;
    state_next = state_reg;
    wr_word  = bus_req.write & bus_req.word;
    wr_timer = wr_word & (bus_req.addr == ADDR_TIMER_WRITE);
    wr_reset = wr_word & (bus_req.addr == ADDR_RESET_WRITE);
    key      = bus_req.wdata[15:8];
    data     = bus_req.wdata[7:0];
    overflow = 1'b0;
    tick     = 1'b0;
    pre_inc  = 12'h000;

    // prescaler runs only while counting so periods start clean
    pre_inc = state_reg.count_run_enable ?
              state_reg.prescaler + 12'h001 : 12'h000;
    state_next.prescaler = pre_inc;
    tick = state_reg.count_run_enable &
           tick_of(state_reg.clock_select, state_reg.prescaler,
                   pre_inc);

    // counter: write wins over a count pulse in the same cycle
    if (wr_timer && key == KEY_COUNTER) begin
      state_next.watch_counter = data;
    end else if (!state_reg.count_run_enable) begin
      state_next.watch_counter = COUNTER_RESET;
    end else if (tick) begin
      state_next.watch_counter = state_reg.watch_counter + 8'h01;
      overflow = (state_reg.watch_counter == 8'hFF);
    end

    // read side: arm the read-then-zero clears
    if (bus_req.read && bus_req.addr == ADDR_CONTROL_READ &&
        state_reg.overflow_flag) begin
      state_next.ovf_seen_set = 1'b1;
    end
    if (bus_req.read && bus_req.addr == ADDR_RESET_READ &&
        state_reg.watchdog_reset_flag) begin
      state_next.watchdog_reset_flag_seen_set = 1'b1;
    end

    // control/status write; flag bit accepts only a zero after a read
    if (wr_timer && key == KEY_CONTROL) begin
      state_next.timer_mode_select = data[BIT_MODE];
      state_next.count_run_enable  = data[BIT_RUN];
      state_next.clock_select      = data[2:0];
      if (!data[BIT_OVERFLOW] && state_reg.ovf_seen_set) begin
        state_next.overflow_flag = 1'b0;
        state_next.ovf_seen_set  = 1'b0;
      end
    end

    // reset control/status writes
    if (wr_reset && key == KEY_CONTROL && data == CLEAR_DATA &&
        state_reg.watchdog_reset_flag_seen_set) begin
      state_next.watchdog_reset_flag = 1'b0;
      state_next.watchdog_reset_flag_seen_set       = 1'b0;
    end
    if (wr_reset && key == KEY_COUNTER) begin
      state_next.reset_output_enable = data[BIT_RESET_OUTPUT_ENABLE];
    end

    // overflow: flag set wins over a clear in the same cycle
    if (overflow) begin
      state_next.overflow_flag = 1'b1;
      if (state_reg.timer_mode_select) begin
        state_next.watchdog_reset_flag = 1'b1;
        state_next.rst_state  = RST_ACTIVE;
        state_next.rst_count  = 10'h000;
        state_next.chip_reset = 1'b1;
        state_next.reset_out_n = ~state_reg.reset_output_enable;
      end
    end

    // internal reset sequencer
    unique case (state_reg.rst_state)
      RST_IDLE: begin
      end
      RST_ACTIVE, RST_OUT_DONE: begin
        state_next.rst_count = state_reg.rst_count + 10'h001;
        if (state_reg.rst_count == OUTPUT_RESET_CYCLES - 10'h001) begin
          state_next.reset_out_n = 1'b1;
          state_next.rst_state   = RST_OUT_DONE;
        end
        if (state_reg.rst_count == INTERNAL_RESET_CYCLES - 10'h001) begin
          state_next.chip_reset = 1'b0;
          state_next.rst_state  = RST_IDLE;
        end
      end
    endcase

    // internal reset clears timer state but not WATCHDOG_RESET_FLAG/RESET_OUTPUT_ENABLE
    if (state_reg.chip_reset) begin
      state_next.watch_counter     = COUNTER_RESET;
      state_next.overflow_flag     = 1'b0;
      state_next.timer_mode_select = 1'b0;
      state_next.count_run_enable  = 1'b0;
      state_next.clock_select      = 3'h0;
      state_next.ovf_seen_set      = 1'b0;
      state_next.prescaler         = 12'h000;
    end

    // interrupt follows the flag in interval mode while counting is enabled
    state_next.irq = state_next.overflow_flag &
                     ~state_next.timer_mode_select &
                     state_next.count_run_enable;

    // registered byte reads
    unique case (bus_req.addr)
      ADDR_CONTROL_READ: state_next.rdata =
        {state_reg.overflow_flag, state_reg.timer_mode_select,
         state_reg.count_run_enable, 2'b11, state_reg.clock_select};
      ADDR_COUNTER_READ: state_next.rdata = state_reg.watch_counter;
      ADDR_RESET_READ:   state_next.rdata =
        {state_reg.watchdog_reset_flag, state_reg.reset_output_enable,
         6'h3F};
      default:           state_next.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers; pin reset overrides everything, including a watchdog
  // reset in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '{watch_counter: COUNTER_RESET,
                     clock_select: 3'h0,
                     watchdog_reset_flag: 1'b0,
                     reset_output_enable: 1'b0,
                     prescaler: 12'h000,
                     rst_count: 10'h000,
                     rst_state: RST_IDLE,
                     rdata: 8'h00,
                     reset_out_n: 1'b1,
                     default: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata              = state_reg.rdata;
  assign interval_interrupt = state_reg.irq;
  assign chip_reset         = state_reg.chip_reset;
  assign reset_out_pin_n    = state_reg.reset_out_n;
endmodule // watchdog_interval_timer

//--- watchdog_interval_timer_bench.sv
// Purpose: self-checking bench for the watchdog interval timer
// Assumes: inputs driven at the falling edge
// Notes:   chip_reset is not fed back; the block clears itself
`timescale 1ns/1ps
module watchdog_interval_timer_bench;
  import wdt_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  bus_req_type bus_req = '0;
  logic [7:0]  rdata;
  logic        interval_interrupt, chip_reset, reset_out_pin_n;
  logic [15:0] pulses, last_width;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #2 clk = ~clk;
  watchdog_interval_timer watchdog_interval_timer_i (.clk(clk),
    .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .interval_interrupt(interval_interrupt), .chip_reset(chip_reset),
    .reset_out_pin_n(reset_out_pin_n));
  reset_out_receiver reset_out_receiver_i (.clk(clk),
    .reset_out_pin_n(reset_out_pin_n), .pulses(pulses),
    .last_width(last_width));
  // --------------------------------------------------------------------
  // bus tasks and checks
  // --------------------------------------------------------------------
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [19:0] a, logic [15:0] d, logic w);
    @(negedge clk);
    bus_req = '{1'b0, 1'b1, w, a, d};
    @(negedge clk);
    bus_req = '0;
  endtask
  task automatic rd(logic [19:0] a, logic [7:0] exp, string name);
    @(negedge clk);
    bus_req = '{1'b1, 1'b0, 1'b0, a, 16'h0000};
    @(negedge clk);
    check(name, {8'h00, exp}, {8'h00, rdata});
    bus_req = '0;
  endtask
  task automatic finish_test();
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // byte writes and wrong keys leave everything alone
  task automatic t_passwords();
    wr(ADDR_TIMER_WRITE, 16'hA527, 1'b0);
    rd(ADDR_CONTROL_READ, 8'h18, "control_status");
    wr(ADDR_TIMER_WRITE, 16'hA527, 1'b1);
    rd(ADDR_CONTROL_READ, 8'h3F, "control_status");
    wr(ADDR_TIMER_WRITE, 16'h5A44, 1'b0);
    wr(ADDR_TIMER_WRITE, 16'h3C44, 1'b1);
    rd(ADDR_COUNTER_READ, 8'h00, "counter_value");
    wr(ADDR_TIMER_WRITE, 16'h5A44, 1'b1);
    rd(ADDR_COUNTER_READ, 8'h44, "counter_value");
    wr(ADDR_TIMER_WRITE, 16'hA507, 1'b1);
    rd(ADDR_COUNTER_READ, 8'h00, "counter_value");
  endtask
  task automatic t_interval();
    int n;
    n = 0;
    wr(ADDR_TIMER_WRITE, 16'hA520, 1'b1);
    wr(ADDR_TIMER_WRITE, 16'h5AFE, 1'b1);
    while (!interval_interrupt && n < 20) begin
      n++;
      @(negedge clk);
    end
    check("interval_interrupt", 16'h0001, {15'h0, interval_interrupt});
    check("chip_reset", 16'h0000, {15'h0, chip_reset});
    rd(ADDR_CONTROL_READ, 8'hB8, "control_status");
    wr(ADDR_TIMER_WRITE, 16'hA520, 1'b1);
    @(negedge clk);
    check("interval_interrupt", 16'h0000, {15'h0, interval_interrupt});
    wr(ADDR_TIMER_WRITE, 16'hA500, 1'b1);
  endtask
  // counter left to overflow in watchdog mode, output enabled or not
  task automatic wdog_run(logic oe);
    int n;
    logic [15:0] seen;
    n = 0;
    seen = pulses;
    wr(ADDR_RESET_WRITE, {KEY_COUNTER, 1'b0, oe, 6'h00}, 1'b1);
    rd(ADDR_RESET_READ, {1'b0, oe, 6'h3F}, "reset_status");
    wr(ADDR_TIMER_WRITE, 16'hA560, 1'b1);
    wr(ADDR_TIMER_WRITE, 16'h5AFE, 1'b1);
    while (!chip_reset && n < 20) begin
      n++;
      @(negedge clk);
    end
    check("reset_out_pin_n", {15'h0, !oe}, {15'h0, reset_out_pin_n});
    n = 0;
    while (chip_reset && n < 1000) begin
      n++;
      @(negedge clk);
    end
    check("chip_reset_len", 16'h0206, n[15:0]);
    check("reset_pulses", seen + {15'h0, oe}, pulses);
    rd(ADDR_RESET_READ, {1'b1, oe, 6'h3F}, "reset_status");
    rd(ADDR_CONTROL_READ, 8'h18, "control_status");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rd(ADDR_CONTROL_READ, 8'h18, "control_status");
    rd(ADDR_COUNTER_READ, 8'h00, "counter_value");
    rd(ADDR_RESET_READ, 8'h3F, "reset_status");
    rd(ADDR_RESET_WRITE, 8'h00, "unmapped");
    t_passwords();
    t_interval();
    wdog_run(1'b1);
    check("reset_out_len", 16'h0084, last_width);
    wr(ADDR_RESET_WRITE, 16'hA500, 1'b1);
    rd(ADDR_RESET_READ, 8'h7F, "reset_status");
    wdog_run(1'b0);
    wr(ADDR_RESET_WRITE, 16'h5A40, 1'b1);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd(ADDR_RESET_READ, 8'h3F, "reset_status");
    finish_test();
  end
endmodule // watchdog_interval_timer_bench

//--- wdt_assertions.sv
// Purpose: port checker for the watchdog interval timer
// Assumes: one clock, async active-high pin reset
// Notes:   pulse widths counted in helper counters
`timescale 1ns/1ps
module wdt_assertions (
  input wire logic                 clk,                // system clock
  input wire logic                 reset,              // pin reset
  input wire wdt_pkg::bus_req_type bus_req,            // register access
  input wire logic [7:0]           rdata,              // read data
  input wire logic                 interval_interrupt, // interval irq
  input wire logic                 chip_reset,         // internal reset
  input wire logic                 reset_out_pin_n     // reset out, low
);
  import wdt_pkg::*;
  logic [9:0] in_cnt;
  logic [9:0] out_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // --------------------------------------------------------------------
  // pulse widths; counts restart whenever the pulse is absent
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_cnt  <= 10'h000;
      out_cnt <= 10'h000;
    end else begin
      in_cnt  <= chip_reset ? in_cnt + 10'h001 : 10'h000;
      out_cnt <= !reset_out_pin_n ? out_cnt + 10'h001 : 10'h000;
    end
  end
  a_internal_len: assert property ($fell(chip_reset) |-> in_cnt == 10'h206)
    else $error("internal reset width wrong");
  a_output_len: assert property ($rose(reset_out_pin_n) |-> out_cnt == 10'h084)
    else $error("reset output width wrong");
  a_output_inside: assert property (!reset_out_pin_n |-> chip_reset)
    else $error("reset output without internal reset");
  a_output_start: assert property ($fell(reset_out_pin_n) |-> $rose(chip_reset))
    else $error("reset output not started with internal reset");
  a_irq_quiet: assert property (chip_reset |-> !interval_interrupt)
    else $error("interrupt during watchdog reset");
  a_irq_clear: assert property ($fell(interval_interrupt) |->
    $past(bus_req.write && bus_req.word))
    else $error("interrupt dropped without a word write");
  a_status_ones: assert property (bus_req.read && bus_req.addr == ADDR_RESET_READ
    |=> rdata[5:0] == 6'h3F)
    else $error("reset status low bits not ones");
  a_control_ones: assert property (bus_req.read && bus_req.addr == ADDR_CONTROL_READ
    |=> rdata[4:3] == 2'h3)
    else $error("control reserved bits not ones");
  c_wdog: cover property ($rose(chip_reset));
  c_irq: cover property ($rose(interval_interrupt));
  c_out: cover property ($fell(reset_out_pin_n));
endmodule // wdt_assertions
bind watchdog_interval_timer wdt_assertions wdt_assertions_i (.clk(clk),
  .reset(reset), .bus_req(bus_req), .rdata(rdata),
  .interval_interrupt(interval_interrupt), .chip_reset(chip_reset),
  .reset_out_pin_n(reset_out_pin_n));

//--- wdt_pkg.sv
// Purpose: constants and types for the watchdog interval timer
// Assumes: 250 MHz system clock, 8-bit register space
// Notes:   one state is one system clock cycle
package wdt_pkg;
  // ----------------------------------------------------------------------
  // register addresses (lower 20 bits)
  // ----------------------------------------------------------------------
  localparam logic [19:0] ADDR_TIMER_WRITE   = 20'hFFF8C;
  localparam logic [19:0] ADDR_RESET_WRITE   = 20'hFFF8E;
  localparam logic [19:0] ADDR_CONTROL_READ  = 20'hFFF8C;
  localparam logic [19:0] ADDR_COUNTER_READ  = 20'hFFF8D;
  localparam logic [19:0] ADDR_RESET_READ    = 20'hFFF8F;
  // ----------------------------------------------------------------------
  // passwords and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] KEY_COUNTER         = 8'h5A;
  localparam logic [7:0] KEY_CONTROL         = 8'hA5;
  localparam logic [7:0] CLEAR_DATA          = 8'h00;
  localparam int         BIT_OVERFLOW        = 7;
  localparam int         BIT_MODE            = 6;
  localparam int         BIT_RUN             = 5;
  localparam int         BIT_WATCHDOG_RESET_FLAG            = 7;
  localparam int         BIT_RESET_OUTPUT_ENABLE           = 6;
  localparam logic [7:0] CONTROL_FIXED_ONES  = 8'h18;
  localparam logic [7:0] RESET_FIXED_ONES    = 8'h3F;
  localparam logic [7:0] COUNTER_RESET       = 8'h00;
  // ----------------------------------------------------------------------
  // timing in states (clock cycles)
  // ----------------------------------------------------------------------
  localparam int          CLOCK_MHZ          = 250;
  localparam int          INTERNAL_RESET_STATES = 518;
  localparam int          OUTPUT_RESET_STATES   = 132;
  localparam logic [9:0]  INTERNAL_RESET_CYCLES =
    10'(INTERNAL_RESET_STATES);
  localparam logic [9:0]  OUTPUT_RESET_CYCLES   =
    10'(OUTPUT_RESET_STATES);
  localparam logic [11:0] PRESCALE_MAX       = 12'hFFF;

  // bus request carried as one group
  typedef struct packed {
    logic        read;
    logic        write;
    logic        word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_req_type;

  typedef enum logic [2:0] {
    RST_IDLE     = 3'b001,
    RST_ACTIVE   = 3'b010,
    RST_OUT_DONE = 3'b100
  } rst_state_type;
endpackage
